/* File: rtl/tic_capture.sv */
// input capture registers, capture flags and interrupt enables of the timer
`timescale 1ns/1ps
// ----------------------------------------
// capture block
// ----------------------------------------
// Notes on behaviour
// - four read-only 16-bit capture registers
// - selected edge copies running count
// - capture flag set with the load
// - load even when flag already set
// - each pin has own edge select
// - buffer a: old a into c
// - buffer b: old b into d
// - differing selects of a buffered pair capture both edges
// - equal pair selects: 0 fall, 1 rise
// - high byte read latches low byte
// - captures zero on reset and standby
// - enable register 8 bits, init 0x01
// - bits 7..4 gate capture requests
// - bits 3,2 gate compare requests
// - bit 1 gates overflow request
// - bit 0 reads one, writes ignored
// - buffer a: pin c only sets flag
// - flag cleared by read-set then write 0
module tic_capture import tic_pkg::*; (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic standby_in,
  input wire logic [CW-1:0] running_count_in,
  input wire logic capture_pin_a_in,
  input wire logic capture_pin_b_in,
  input wire logic capture_pin_c_in,
  input wire logic capture_pin_d_in,
  input wire logic compare_flag_a_in,
  input wire logic compare_flag_b_in,
  input wire logic overflow_flag_in,
  input wire logic [AW-1:0] addr_in,
  input wire logic [DW-1:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [DW-1:0] rd_data_out,
  output tic_irq_t irq_out
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [NCH-1:0] pins;
  logic [NCH-1:0] sync1;
  logic [NCH-1:0] sync2;
  logic [NCH-1:0] prev;
  logic [1:0] warm;
  logic [NCH-1:0] rise;
  logic [NCH-1:0] fall;
  logic [NCH-1:0] single;
  logic [NCH-1:0] ev;
  logic [CW-1:0] cap [NCH];
  logic [NCH-1:0] flags;
  logic [NCH-1:0] armed;
  logic [DW-1:0] ier;
  logic [NCH-1:0] edge_sel;
  logic buffer_en_a;
  logic buffer_en_b;
  logic [BW-1:0] temp;
  logic [DW-1:0] next_rd_data;
  logic clr_all;
  logic wr_ier;
  logic wr_flag;
  logic wr_ctrl;
  logic rd_flag;
  logic cap_rd;
  logic [1:0] cap_ch;
  logic [NCH-1:0] cap_en;
  logic [NCH-1:0] flag_bits;
  logic [NCH-1:0] clr;

  assign pins = {capture_pin_d_in, capture_pin_c_in, capture_pin_b_in, capture_pin_a_in};
  // standby joins reset in clr_all, whose clears act only while the clock is enabled
  assign clr_all = srst_in | standby_in;

  // ----------------------------------------
  // register decode
  // ----------------------------------------
  assign wr_ier = wr_in & (addr_in == OFS_IER);
  assign wr_flag = wr_in & (addr_in == OFS_FLAG);
  assign wr_ctrl = wr_in & (addr_in == OFS_CTRL);
  assign rd_flag = rd_in & (addr_in == OFS_FLAG);
  assign cap_rd = rd_in & addr_in[CAP_SEL_BIT];
  assign cap_ch = addr_in[CAP_CH_HI:CAP_CH_LO];
  // channel a sits in the top flag bit
  assign cap_en = {ier[CAPF_D_BIT], ier[CAPF_D_BIT+1], ier[CAPF_A_BIT-1], ier[CAPF_A_BIT]};
  assign flag_bits = {flags[CH_A], flags[CH_B], flags[CH_C], flags[CH_D]};
  assign clr = armed & ~{wr_data_in[CAPF_D_BIT], wr_data_in[CAPF_D_BIT+1],
                         wr_data_in[CAPF_A_BIT-1], wr_data_in[CAPF_A_BIT]};

  // ----------------------------------------
  // pin synchroniser and edge detection
  // ----------------------------------------
  // three flops per pin; sync2 and its delayed copy prev feed the detector, sync1 does not
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      sync1 <= FLAGS_INIT;
      sync2 <= FLAGS_INIT;
      prev <= FLAGS_INIT;
    end else if (ce_in) begin
      sync1 <= pins;
      sync2 <= sync1;
      prev <= sync2;
    end
  end

  // hold off detection until prev is valid, so a high pin at reset is no edge
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      warm <= 2'h0;
    end else if (ce_in && warm != WARM_CYC) begin
      warm <= warm + 2'h1;
    end
  end

  always_comb begin
    rise = (warm == WARM_CYC) ? (sync2 & ~prev) : FLAGS_INIT;
    fall = (warm == WARM_CYC) ? (~sync2 & prev) : FLAGS_INIT;
    single = (edge_sel & rise) | (~edge_sel & fall);
    ev = single;
    // a buffered pair with differing selects takes both edges of its primary pin
    if (buffer_en_a && (edge_sel[CH_A] != edge_sel[CH_C])) begin
      ev[CH_A] = rise[CH_A] | fall[CH_A];
    end
    if (buffer_en_b && (edge_sel[CH_B] != edge_sel[CH_D])) begin
      ev[CH_B] = rise[CH_B] | fall[CH_B];
    end
  end

  // ----------------------------------------
  // capture registers
  // ----------------------------------------
  // loads ignore the flag state, so an unread value is overwritten
  always_ff @(posedge clk_in) begin
    if (ce_in) begin
      if (clr_all) begin
        for (int k = 0; k < NCH; k++) begin
          cap[k] <= CAP_INIT;
        end
      end else begin
        if (ev[CH_A]) begin
          cap[CH_A] <= running_count_in;
        end
        if (ev[CH_B]) begin
          cap[CH_B] <= running_count_in;
        end
        if (buffer_en_a) begin
          if (ev[CH_A]) begin
            cap[CH_C] <= cap[CH_A];
          end
        end else if (ev[CH_C]) begin
          cap[CH_C] <= running_count_in;
        end
        if (buffer_en_b) begin
          if (ev[CH_B]) begin
            cap[CH_D] <= cap[CH_B];
          end
        end else if (ev[CH_D]) begin
          cap[CH_D] <= running_count_in;
        end
      end
    end
  end

  // ----------------------------------------
  // capture flags
  // ----------------------------------------
  // a new event beats a clear in the same cycle; writing 1 does nothing
  always_ff @(posedge clk_in) begin
    if (ce_in) begin
      if (clr_all) begin
        flags <= FLAGS_INIT;
      end else if (wr_flag) begin
        flags <= ev | (flags & ~clr);
      end else begin
        flags <= ev | flags;
      end
    end
  end

  // a flag may only be cleared after it was read as one
  always_ff @(posedge clk_in) begin
    if (ce_in) begin
      if (clr_all || wr_flag) begin
        armed <= FLAGS_INIT;
      end else if (rd_flag) begin
        armed <= armed | flags;
      end
    end
  end

  // ----------------------------------------
  // enable and control registers
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (ce_in) begin
      if (clr_all) begin
        ier <= IER_INIT;
      end else if (wr_ier) begin
        ier <= wr_data_in | IER_INIT;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (ce_in) begin
      if (clr_all) begin
        edge_sel <= CTRL_INIT[CAPF_A_BIT:CAPF_D_BIT];
        buffer_en_a <= CTRL_INIT[BUFA_BIT];
        buffer_en_b <= CTRL_INIT[BUFB_BIT];
      end else if (wr_ctrl) begin
        edge_sel <= {wr_data_in[CAPF_D_BIT], wr_data_in[CAPF_D_BIT+1],
                     wr_data_in[CAPF_A_BIT-1], wr_data_in[CAPF_A_BIT]};
        buffer_en_a <= wr_data_in[BUFA_BIT];
        buffer_en_b <= wr_data_in[BUFB_BIT];
      end
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  // high byte read snapshots the low byte, so both halves match
  always_ff @(posedge clk_in) begin
    if (ce_in) begin
      if (clr_all) begin
        temp <= CAP_INIT[BW-1:0];
      end else if (cap_rd && !addr_in[CAP_BYTE_BIT]) begin
        temp <= cap[cap_ch][BW-1:0];
      end
    end
  end

  always_comb begin
    next_rd_data = '0;
    if (cap_rd) begin
      // the low byte comes from temp, never live, so a capture between reads is harmless
      next_rd_data = addr_in[CAP_BYTE_BIT] ? temp : cap[cap_ch][CW-1:BW];
    end else if (rd_in) begin
      case (addr_in)
        OFS_IER: next_rd_data = ier | IER_INIT;
        OFS_FLAG: begin
          next_rd_data[CAPF_A_BIT:CAPF_D_BIT] = flag_bits;
          next_rd_data[CMPA_BIT] = compare_flag_a_in;
          next_rd_data[CMPB_BIT] = compare_flag_b_in;
          next_rd_data[OVERFLOW_BIT] = overflow_flag_in;
        end
        OFS_CTRL: begin
          next_rd_data[CAPF_A_BIT:CAPF_D_BIT] = {edge_sel[CH_A], edge_sel[CH_B], edge_sel[CH_C], edge_sel[CH_D]};
          next_rd_data[BUFA_BIT] = buffer_en_a;
          next_rd_data[BUFB_BIT] = buffer_en_b;
        end
        default: next_rd_data = '0;
      endcase
    end
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rd_data_out <= '0;
    end else if (ce_in) begin
      rd_data_out <= next_rd_data;
    end
  end

  // ----------------------------------------
  // interrupt requests
  // ----------------------------------------
  // registered, so a request follows its flag by one cycle
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      irq_out <= '0;
    end else if (ce_in) begin
      irq_out.cap_irq <= flags & cap_en;
      irq_out.cmp_irq_a <= compare_flag_a_in & ier[CMPA_BIT];
      irq_out.cmp_irq_b <= compare_flag_b_in & ier[CMPB_BIT];
      irq_out.overflow_irq <= overflow_flag_in & ier[OVERFLOW_BIT];
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);

  // capture loads, buffer moves and edge choice
  chk_cap_a_load: assert property (
    ce_in && !standby_in && ev[CH_A] |=> cap[CH_A] == $past(running_count_in))
    else $error("capture a missed the count");
  chk_cap_b_load: assert property (
    ce_in && !standby_in && ev[CH_B] |=> cap[CH_B] == $past(running_count_in))
    else $error("capture b missed the count");
  chk_cap_c_load: assert property (
    ce_in && !standby_in && !buffer_en_a && ev[CH_C] |=> cap[CH_C] == $past(running_count_in))
    else $error("capture c missed the count");
  chk_cap_d_load: assert property (
    ce_in && !standby_in && !buffer_en_b && ev[CH_D] |=> cap[CH_D] == $past(running_count_in))
    else $error("capture d missed the count");
  chk_load_over_flag: assert property (
    ce_in && !standby_in && flags[CH_A] && ev[CH_A] |=> cap[CH_A] == $past(running_count_in))
    else $error("set flag blocked a capture");
  chk_cap_stable: assert property (
    ce_in && !standby_in && ev == '0 |=> $stable(cap[CH_A]) && $stable(cap[CH_B])
    && $stable(cap[CH_C]) && $stable(cap[CH_D]))
    else $error("capture changed without an event");
  chk_flag_a_set: assert property (
    ce_in && !standby_in && ev[CH_A] |=> flags[CH_A])
    else $error("capture flag a not set");
  chk_flag_set: assert property (
    ce_in && !standby_in && ev[CH_B] |=> flags[CH_B])
    else $error("capture flag b not set");
  chk_buf_a_move: assert property (
    ce_in && !standby_in && buffer_en_a && ev[CH_A] |=> cap[CH_C] == $past(cap[CH_A]))
    else $error("buffer c did not get old a");
  chk_buf_b_move: assert property (
    ce_in && !standby_in && buffer_en_b && ev[CH_B] |=> cap[CH_D] == $past(cap[CH_B]))
    else $error("buffer d did not get old b");
  chk_both_edge: assert property (
    buffer_en_a && edge_sel[CH_A] != edge_sel[CH_C] && (rise[CH_A] || fall[CH_A]) |-> ev[CH_A])
    else $error("both-edge capture missed");
  chk_rise_only: assert property (
    buffer_en_b && edge_sel[CH_B] && edge_sel[CH_D] && fall[CH_B] |-> !ev[CH_B])
    else $error("falling edge taken by a rise-only pair");
  chk_fall_only: assert property (
    buffer_en_b && !edge_sel[CH_B] && !edge_sel[CH_D] && rise[CH_B] |-> !ev[CH_B])
    else $error("rising edge taken by a fall-only pair");
  chk_pin_c_flag: assert property (
    ce_in && !standby_in && buffer_en_a && ev[CH_C] && !ev[CH_A] |=> flags[CH_C] && $stable(cap[CH_C]))
    else $error("pin c loaded a count in buffer mode");
  chk_pin_d_flag: assert property (
    ce_in && !standby_in && buffer_en_b && ev[CH_D] && !ev[CH_B] |=> flags[CH_D] && $stable(cap[CH_D]))
    else $error("pin d loaded a count in buffer mode");
  chk_sync_chain: assert property (
    ce_in |=> sync2 == $past(sync1))
    else $error("synchroniser stage skipped");
  chk_warm_quiet: assert property (
    warm != WARM_CYC |-> ev == '0)
    else $error("edge taken before the synchroniser settled");

  // register side and interrupt requests
  chk_standby_clr: assert property (
    ce_in && standby_in |=> cap[CH_A] == CAP_INIT && cap[CH_D] == CAP_INIT && ier == IER_INIT)
    else $error("standby did not clear");
  chk_ier_write: assert property (
    ce_in && !standby_in && wr_ier |=> ier == ($past(wr_data_in) | IER_INIT))
    else $error("enable register write lost");
  chk_ier_rsv: assert property (
    ier[RSV_BIT])
    else $error("reserved enable bit cleared");
  chk_rsv_read: assert property (
    rd_in && ce_in && addr_in == OFS_IER |=> rd_data_out[RSV_BIT])
    else $error("reserved bit read zero");
  chk_low_from_temp: assert property (
    ce_in && cap_rd && addr_in[CAP_BYTE_BIT] |=> rd_data_out == $past(temp))
    else $error("low byte not taken from the snapshot");
  chk_irq_gate: assert property (
    ce_in |=> irq_out.cap_irq == $past(flags & cap_en))
    else $error("capture request not gated");
  chk_cmp_a_gate: assert property (
    ce_in |=> irq_out.cmp_irq_a == $past(compare_flag_a_in & ier[CMPA_BIT]))
    else $error("compare request a not gated");
  chk_cmp_b_gate: assert property (
    ce_in |=> irq_out.cmp_irq_b == $past(compare_flag_b_in & ier[CMPB_BIT]))
    else $error("compare request b not gated");
  chk_overflow_gate: assert property (
    ce_in |=> irq_out.overflow_irq == $past(overflow_flag_in & ier[OVERFLOW_BIT]))
    else $error("overflow request not gated");
  chk_clear_armed: assert property (
    ce_in && !standby_in && wr_flag && !armed[CH_A] && flags[CH_A] |=> flags[CH_A])
    else $error("flag cleared without prior read");
  chk_flag_hold: assert property (
    ce_in && !standby_in && flags[CH_B] && !(wr_flag && armed[CH_B]) |=> flags[CH_B])
    else $error("flag b cleared without read and write");
endmodule : tic_capture

/* File: rtl/tic_pkg.sv */
// shared constants and types for the capture and interrupt-enable block
package tic_pkg;
  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int unsigned DW = 8;
  localparam int unsigned AW = 4;
  localparam int unsigned CW = 16;
  localparam int unsigned BW = 8;
  localparam int unsigned NCH = 4;
  // ----------------------------------------
  // channel indices
  // ----------------------------------------
  localparam int unsigned CH_A = 0;
  localparam int unsigned CH_B = 1;
  localparam int unsigned CH_C = 2;
  localparam int unsigned CH_D = 3;
  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [AW-1:0] OFS_IER = 4'h0;
  localparam logic [AW-1:0] OFS_FLAG = 4'h1;
  localparam logic [AW-1:0] OFS_CTRL = 4'h6;
  // capture a..d high/low at 0x8..0xF
  localparam int unsigned CAP_SEL_BIT = 3;
  localparam int unsigned CAP_CH_HI = 2;
  localparam int unsigned CAP_CH_LO = 1;
  localparam int unsigned CAP_BYTE_BIT = 0;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int unsigned CAPF_A_BIT = 7;
  localparam int unsigned CAPF_D_BIT = 4;
  localparam int unsigned CMPA_BIT = 3;
  localparam int unsigned CMPB_BIT = 2;
  localparam int unsigned OVERFLOW_BIT = 1;
  localparam int unsigned RSV_BIT = 0;
  localparam int unsigned BUFA_BIT = 3;
  localparam int unsigned BUFB_BIT = 2;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [DW-1:0] IER_INIT = 8'h01;
  localparam logic [DW-1:0] CTRL_INIT = 8'h00;
  localparam logic [CW-1:0] CAP_INIT = 16'h0000;
  localparam logic [NCH-1:0] FLAGS_INIT = 4'h0;
  localparam logic [1:0] WARM_CYC = 2'h3;
  // ----------------------------------------
  // interrupt request bundle
  // ----------------------------------------
  typedef struct packed {
    logic [NCH-1:0] cap_irq;
    logic cmp_irq_a;
    logic cmp_irq_b;
    logic overflow_irq;
  } tic_irq_t;
endpackage : tic_pkg

/* File: tb/tb.sv */
// self-checking bench for the capture and interrupt-enable block
`timescale 1ns/1ps
module tb;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic standby = 1'b0;
  logic ce = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [3:0] want = 4'h0;
  logic [3:0] pins;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [15:0] cnt = 16'h0000;
  logic [2:0] cmpf = 3'h0;
  logic [6:0] irq;
  int fail_count = 0;
  int n_compared = 0;
  always #4 clk_in = ~clk_in;
  tic_pulse_src u_src (.clk_in(clk_in), .want_in(want), .pins_out(pins));
  // ce drops once, to show that standby only acts on an enabled edge
  tic_capture u_dut (.clk_in(clk_in), .srst_in(srst_in), .ce_in(ce), .standby_in(standby),
    .running_count_in(cnt), .capture_pin_a_in(pins[0]), .capture_pin_b_in(pins[1]),
    .capture_pin_c_in(pins[2]), .capture_pin_d_in(pins[3]), .compare_flag_a_in(cmpf[2]),
    .compare_flag_b_in(cmpf[1]), .overflow_flag_in(cmpf[0]), .addr_in(addr),
    .wr_data_in(wdata), .wr_in(wr), .rd_in(rd), .rd_data_out(rdata), .irq_out(irq));
  // ------
  // helpers
  // ------
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // a gap cycle after each write keeps the strobe to one assignment per step
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
    @(posedge clk_in);
  endtask : wreg
  // read data stand only in the cycle after the strobe, sampled mid-cycle
  task automatic rc(input string n, input logic [3:0] a, input logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    @(negedge clk_in);
    chk(n, 16'(e), 16'(rdata));
    @(posedge clk_in);
  endtask : rc
  // high byte first so the low byte comes from the same captured value
  task automatic cc(input string n, input int ch, input logic [15:0] e);
    rc(n, 4'h8 + 4'(2 * ch), e[15:8]);
    rc(n, 4'h9 + 4'(2 * ch), e[7:0]);
  endtask : cc
  // the count is held still around the edge so the latch point cannot blur it
  task automatic pin(input int ch, input logic v, input logic [15:0] c);
    cnt <= c;
    want[ch] <= v;
    repeat (7) @(posedge clk_in);
  endtask : pin
  // ------
  // scenarios
  // ------
  task automatic t_reset;
    rc("ier reset", 4'h0, 8'h01);
    for (int i = 0; i < 4; i++) cc("cap reset", i, 16'h0000);
    wreg(4'h0, 8'h00);
    rc("ier bit0", 4'h0, 8'h01);
    wreg(4'h0, 8'hFE);
    rc("ier rw", 4'h0, 8'hFF);
    wreg(4'h8, 8'hAA);
    cc("cap ro", 0, 16'h0000);
    rc("unmapped", 4'h2, 8'h00);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_capture;
    wreg(4'h6, 8'hF0);
    for (int i = 0; i < 4; i++) begin
      pin(i, 1'b1, 16'h1230 + 16'(i));
      cc("cap rise", i, 16'h1230 + 16'(i));
    end
    rc("flags set", 4'h1, 8'hF0);
    pin(0, 1'b0, 16'h5678);
    cc("cap a fall", 0, 16'h1230);
    pin(0, 1'b1, 16'hABCD);
    cc("cap a again", 0, 16'hABCD);
    $display("t_capture done");
  endtask : t_capture
  task automatic t_irq;
    logic [7:0] e;
    cmpf <= 3'h7;
    for (int b = 0; b < 8; b++) begin
      e = 8'h01 << b;
      wreg(4'h0, e);
      @(negedge clk_in);
      chk("irq gate", 16'({e[4], e[5], e[6], e[7], e[3:1]}), 16'(irq));
      @(posedge clk_in);
    end
    rc("flag mirror", 4'h1, 8'hFE);
    cmpf <= 3'h0;
    wreg(4'h1, 8'hFF);
    wreg(4'h1, 8'h00);
    rc("no clear unread", 4'h1, 8'hF0);
    wreg(4'h1, 8'h70);
    rc("clear a", 4'h1, 8'h70);
    $display("t_irq done");
  endtask : t_irq
  task automatic t_bufa;
    wreg(4'h6, 8'h88);
    pin(0, 1'b0, 16'h1111);
    cc("buf a new", 0, 16'h1111);
    cc("buf a old", 2, 16'hABCD);
    pin(0, 1'b1, 16'h2222);
    cc("buf a rise", 0, 16'h2222);
    cc("buf c shift", 2, 16'h1111);
    wreg(4'h1, 8'hDF);
    rc("clear c", 4'h1, 8'hD0);
    pin(2, 1'b0, 16'h3333);
    rc("flag c only", 4'h1, 8'hF0);
    cc("cap c kept", 2, 16'h1111);
    $display("t_bufa done");
  endtask : t_bufa
  task automatic t_bufb;
    wreg(4'h6, 8'h04);
    pin(1, 1'b0, 16'h4444);
    cc("buf b fall", 1, 16'h4444);
    cc("buf d old", 3, 16'h1231);
    pin(3, 1'b0, 16'h8888);
    cc("cap d kept", 3, 16'h1231);
    pin(1, 1'b1, 16'h5555);
    cc("buf b no rise", 1, 16'h4444);
    wreg(4'h6, 8'h54);
    rc("ctrl rw", 4'h6, 8'h54);
    pin(1, 1'b0, 16'h6666);
    cc("buf b no fall", 1, 16'h4444);
    pin(1, 1'b1, 16'h7777);
    cc("buf b rise", 1, 16'h7777);
    cc("buf d shift", 3, 16'h4444);
    $display("t_bufb done");
  endtask : t_bufb
  task automatic t_standby;
    // a capture between the two byte reads must not tear the value
    rc("snap hi", 4'h8, 8'h22);
    pin(0, 1'b0, 16'h9876);
    rc("snap lo", 4'h9, 8'h22);
    cc("cap a new", 0, 16'h9876);
    ce <= 1'b0;
    standby <= 1'b1;
    repeat (2) @(posedge clk_in);
    ce <= 1'b1;
    standby <= 1'b0;
    @(posedge clk_in);
    rc("ier frozen", 4'h0, 8'h81);
    cc("cap frozen", 0, 16'h9876);
    standby <= 1'b1;
    @(posedge clk_in);
    standby <= 1'b0;
    @(posedge clk_in);
    cc("cap standby", 1, 16'h0000);
    rc("ier standby", 4'h0, 8'h01);
    rc("flags standby", 4'h1, 8'h00);
    $display("t_standby done");
  endtask : t_standby
  // main sequence: reset held six cycles, then every scenario in turn
  initial begin
    repeat (6) @(posedge clk_in);
    srst_in <= 1'b0;
    @(posedge clk_in);
    t_reset();
    t_capture();
    t_irq();
    t_bufa();
    t_bufb();
    t_standby();
    test_done();
  end
  // watchdog: a hang counts as a mismatch
  initial begin
    #200000;
    fail_count++;
    test_done();
  end
endmodule : tb

/* File: tb/tic_pulse_src.sv */
// behavioural model of the external pulse sources on the capture pins
`timescale 1ns/1ps
module tic_pulse_src (
  input wire logic clk_in,
  input wire logic [3:0] want_in,
  output logic [3:0] pins_out
);
  logic [1:0] hold = 2'h0;
  logic [3:0] level = 4'h0;
  // ------
  // pin driver
  // ------
  // follow the request, but keep each level four clocks so that even
  // a two-edge capture never sees a pulse narrower than allowed
  always @(posedge clk_in) begin
    if (hold != 2'h0) begin
      hold <= hold - 2'h1;
    end else if (want_in != level) begin
      level <= want_in;
      hold <= 2'h3;
    end
  end
  // one driver for the pins, idle low from time zero
  assign pins_out = level;
endmodule : tic_pulse_src
